/* File: verilog/acfg_params.svh */
/*
 * Offsets, field positions, reset values and masks of the audio function
 * configuration header.
 * Assumes it is included by bare name from the package and the design files.
 */
`ifndef ACFG_PARAMS_SVH
`define ACFG_PARAMS_SVH

// ----------------------------------------------------------------------------
// Byte offsets of the registers
// ----------------------------------------------------------------------------
`define ACFG_OFF_MAKER       8'h00
`define ACFG_OFF_PART        8'h02
`define ACFG_OFF_COMMAND     8'h04
`define ACFG_OFF_STATUS      8'h06
`define ACFG_OFF_REVISION    8'h08
`define ACFG_OFF_PROG_IF     8'h09
`define ACFG_OFF_SUB_CLASS   8'h0a
`define ACFG_OFF_BASE_CLASS  8'h0b
`define ACFG_OFF_HEADER      8'h0e
`define ACFG_OFF_MIXER_BAR   8'h10
`define ACFG_OFF_BM_BAR      8'h14
`define ACFG_OFF_RSVD_18     8'h18
`define ACFG_OFF_BOARD_VEN   8'h2c
`define ACFG_OFF_BOARD       8'h2e
`define ACFG_OFF_INT_LINE    8'h3c
`define ACFG_OFF_INT_PIN     8'h3d

// ----------------------------------------------------------------------------
// Command and status bit positions
// ----------------------------------------------------------------------------
`define ACFG_CMD_IO_BIT      0
`define ACFG_CMD_MEM_BIT     1
`define ACFG_CMD_MASTER_BIT  2
`define ACFG_STA_ABORT_BIT   13

// ----------------------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------------------
`define ACFG_CMD_RESET       16'h0000
`define ACFG_STA_FIXED       16'h0280
`define ACFG_PROG_IF_VAL     8'h00
`define ACFG_SUB_CLASS_VAL   8'h01
`define ACFG_BASE_CLASS_VAL  8'h04
`define ACFG_HEADER_VAL      8'h00
`define ACFG_BAR_RESET       32'h0000_0001
`define ACFG_RSVD_18_VAL     32'h0000_0001
`define ACFG_BOARD_RESET     16'h0000
`define ACFG_INT_LINE_RESET  8'h00
`define ACFG_INT_PIN_VAL     8'h02

// ----------------------------------------------------------------------------
// Writable bit masks per 32-bit word
// ----------------------------------------------------------------------------
`define ACFG_WM_COMMAND      32'h0000_0005
`define ACFG_WM_MIXER_BAR    32'h0000_ff00
`define ACFG_WM_BM_BAR       32'h0000_ffc0
`define ACFG_WM_BOARD        32'hffff_ffff
`define ACFG_WM_INT_LINE     32'h0000_00ff
`define ACFG_WM_NONE         32'h0000_0000

`endif

/* File: verilog/acfg_pkg.sv */
/*
 * Types shared by the configuration header design files.
 * Assumes acfg_params.svh is on the include path.
 */
`default_nettype none

`include "acfg_params.svh"

package acfg_pkg;

	// ------------------------------------------------------------------------
	// Configuration request and answer carriers
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  addr;   // Byte address, bits 1:0 ignored
		logic [3:0]  be;     // Byte enables, active high
		logic [31:0] wdata;
	} cfg_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} cfg_rsp_t;

	// I/O cycle offered to the function for decode
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} io_req_t;

endpackage

`default_nettype wire

/* File: verilog/cfg_write_merge.sv */
/*
 * Byte-enable merge of a write into the current value of a 32-bit word,
 * limited to the bits that the mask marks writable.
 * Assumes purely combinational use on the same clock as the caller.
 */
`timescale 1ns/1ps
`default_nettype none

module cfg_write_merge #(
	parameter int BYTES = 4
) (
	input  wire logic [8*BYTES-1:0] old_in,
	input  wire logic [8*BYTES-1:0] wdata_in,
	input  wire logic [8*BYTES-1:0] wmask_in,
	input  wire logic [BYTES-1:0]   be_in,
	output logic      [8*BYTES-1:0] merged_out
);

	// ------------------------------------------------------------------------
	// Per-byte merge
	// ------------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < BYTES; g = g + 1) begin : g_byte
			// Enabled byte takes written bits where writable
			assign merged_out[8*g +: 8] = be_in[g]
				? ((old_in[8*g +: 8] & ~wmask_in[8*g +: 8])
					| (wdata_in[8*g +: 8] & wmask_in[8*g +: 8]))
				: old_in[8*g +: 8];
		end
	endgenerate

endmodule // cfg_write_merge

`default_nettype wire

/* File: verilog/audio_function_pci_config_space.sv */
/*
 * Configuration header of the audio controller function: identity codes,
 * command and status, two I/O base addresses, board codes, interrupt line.
 * Assumes the host side delivers one configuration request per valid cycle,
 * and that bus-master and I/O-cycle signals come from logic on clk_in.
 */
// What this block does
// - Unlisted offsets are reserved, read-only, and ignore writes.
// - Command bit 2 gates starting any bus-master cycle.
// - Command bit 1 reads zero; memory cycles are never claimed.
// - Command bit 0 gates I/O register decode; zero after reset.
// - Command bits 15:3 read zero and cannot be written.
// - Maker code is a fixed read-only value; writes ignored.
// - Status bit 13 set on master abort; software writes one to clear.

`timescale 1ns/1ps
`default_nettype none

`include "acfg_params.svh"

module audio_function_pci_config_space
	import acfg_pkg::*;
#(
	parameter logic [15:0] MAKER_CODE    = 16'h1234, // Arbitrary value
	parameter logic [15:0] PART_CODE     = 16'h5678, // Arbitrary value
	parameter logic [7:0]  REVISION_CODE = 8'h01     // Arbitrary value
) (
	input  wire logic     clk_in,
	input  wire logic     rstn_in,
	input  wire cfg_req_t cfg_req_in,
	output var  cfg_rsp_t cfg_rsp_out,
	input  wire logic     master_req_in,
	input  wire logic     master_abort_in,
	output logic          master_grant_out,
	input  wire io_req_t  io_req_in,
	output logic          io_claim_mixer_out,
	output logic          io_claim_bm_out,
	output logic          mem_claim_out,
	output logic          io_enable_out,
	output logic          master_enable_out
);

	// ------------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------------
	logic        io_en_q,        io_en_d;
	logic        master_en_q,    master_en_d;
	logic        abort_flag_q,   abort_flag_d;
	logic [31:0] mixer_bar_q,    mixer_bar_d;
	logic [31:0] bm_bar_q,       bm_bar_d;
	logic [31:0] board_q,        board_d;
	logic        board_lock_q,   board_lock_d;
	logic [7:0]  int_line_q,     int_line_d;
	cfg_rsp_t    rsp_q,          rsp_d;
	logic        grant_q,        grant_d;
	logic        claim_mix_q,    claim_mix_d;
	logic        claim_bm_q,     claim_bm_d;

	// ------------------------------------------------------------------------
	// Address decode of the addressed word
	// ------------------------------------------------------------------------
	logic [5:0]  word_idx;
	logic        hit_id;
	logic        hit_cmd;
	logic        hit_class;
	logic        hit_header;
	logic        hit_mixer;
	logic        hit_bm;
	logic        hit_rsvd18;
	logic        hit_board;
	logic        hit_int;
	logic        wr_en;

	// Word compare against each register's byte offset
	assign word_idx   = cfg_req_in.addr[7:2];
	assign hit_id     = ({word_idx, 2'b00} == (`ACFG_OFF_MAKER & 8'hfc));
	assign hit_cmd    = ({word_idx, 2'b00} == (`ACFG_OFF_COMMAND & 8'hfc));
	assign hit_class  = ({word_idx, 2'b00} == (`ACFG_OFF_REVISION & 8'hfc));
	assign hit_header = ({word_idx, 2'b00} == (`ACFG_OFF_HEADER & 8'hfc));
	assign hit_mixer  = ({word_idx, 2'b00} == (`ACFG_OFF_MIXER_BAR & 8'hfc));
	assign hit_bm     = ({word_idx, 2'b00} == (`ACFG_OFF_BM_BAR & 8'hfc));
	assign hit_rsvd18 = ({word_idx, 2'b00} == (`ACFG_OFF_RSVD_18 & 8'hfc));
	assign hit_board  = ({word_idx, 2'b00} == (`ACFG_OFF_BOARD_VEN & 8'hfc));
	assign hit_int    = ({word_idx, 2'b00} == (`ACFG_OFF_INT_LINE & 8'hfc));
	assign wr_en      = cfg_req_in.valid & cfg_req_in.write;

	// ------------------------------------------------------------------------
	// Current word values as software sees them
	// ------------------------------------------------------------------------
	logic [15:0] command_view;
	logic [15:0] status_view;
	logic [31:0] read_word;
	logic [31:0] wmask_word;
	logic [31:0] merged_word;

	// Command view: only decode and master bits live
	always_comb begin
		command_view = `ACFG_CMD_RESET;
		command_view[`ACFG_CMD_IO_BIT]     = io_en_q;
		command_view[`ACFG_CMD_MASTER_BIT] = master_en_q;
		command_view[`ACFG_CMD_MEM_BIT]    = 1'b0;
	end

	// Status view: fixed capability bits plus abort flag
	always_comb begin
		status_view = `ACFG_STA_FIXED;
		status_view[`ACFG_STA_ABORT_BIT] = abort_flag_q;
	end

	// Read multiplexer over the addressed word
	always_comb begin
		read_word  = 32'h0000_0000;
		wmask_word = `ACFG_WM_NONE;
		if (hit_id) begin
			read_word = {PART_CODE, MAKER_CODE};
		end else if (hit_cmd) begin
			read_word  = {status_view, command_view};
			wmask_word = `ACFG_WM_COMMAND;
		end else if (hit_class) begin
			read_word = {`ACFG_BASE_CLASS_VAL, `ACFG_SUB_CLASS_VAL,
				`ACFG_PROG_IF_VAL, REVISION_CODE};
		end else if (hit_header) begin
			read_word = {8'h00, `ACFG_HEADER_VAL, 16'h0000};
		end else if (hit_mixer) begin
			read_word  = mixer_bar_q;
			wmask_word = `ACFG_WM_MIXER_BAR;
		end else if (hit_bm) begin
			read_word  = bm_bar_q;
			wmask_word = `ACFG_WM_BM_BAR;
		end else if (hit_rsvd18) begin
			read_word = `ACFG_RSVD_18_VAL;
		end else if (hit_board) begin
			read_word  = board_q;
			wmask_word = board_lock_q ? `ACFG_WM_NONE : `ACFG_WM_BOARD;
		end else if (hit_int) begin
			read_word  = {16'h0000, `ACFG_INT_PIN_VAL, int_line_q};
			wmask_word = `ACFG_WM_INT_LINE;
		end else begin
			// unlisted words read zero, mask stays empty
			read_word  = 32'h0000_0000;
			wmask_word = `ACFG_WM_NONE;
		end
	end

	// ------------------------------------------------------------------------
	// Write merge under byte enables and writable mask
	// ------------------------------------------------------------------------
	cfg_write_merge #(
		.BYTES (4)
	) u_merge (
		.old_in     (read_word),
		.wdata_in   (cfg_req_in.wdata),
		.wmask_in   (wmask_word),
		.be_in      (cfg_req_in.be),
		.merged_out (merged_word)
	);

	// ------------------------------------------------------------------------
	// Configuration register next values
	// ------------------------------------------------------------------------
	logic abort_clear;

	// Write-one-to-clear of the abort flag in the status upper byte
	assign abort_clear = wr_en & hit_cmd & cfg_req_in.be[3]
		& cfg_req_in.wdata[16 + `ACFG_STA_ABORT_BIT];

	always_comb begin
		io_en_d      = io_en_q;
		master_en_d  = master_en_q;
		abort_flag_d = abort_flag_q;
		mixer_bar_d  = mixer_bar_q;
		bm_bar_d     = bm_bar_q;
		board_d      = board_q;
		board_lock_d = board_lock_q;
		int_line_d   = int_line_q;
		if (wr_en && hit_cmd) begin
			io_en_d     = merged_word[`ACFG_CMD_IO_BIT];
			master_en_d = merged_word[`ACFG_CMD_MASTER_BIT];
		end
		if (wr_en && hit_mixer) begin
			mixer_bar_d = merged_word;
		end
		if (wr_en && hit_bm) begin
			bm_bar_d = merged_word;
		end
		if (wr_en && hit_board && !board_lock_q) begin
			// First write with any byte enabled locks the board codes
			board_d = merged_word;
			if (cfg_req_in.be != 4'h0) begin
				board_lock_d = 1'b1;
			end
		end
		if (wr_en && hit_int) begin
			int_line_d = merged_word[7:0];
		end
		// clear by writing one, a new abort wins
		if (abort_clear) begin
			abort_flag_d = 1'b0;
		end
		if (master_abort_in) begin
			abort_flag_d = 1'b1;
		end
	end

	// Register the configuration state
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			io_en_q      <= 1'b0;
			master_en_q  <= 1'b0;
			abort_flag_q <= 1'b0;
			mixer_bar_q  <= `ACFG_BAR_RESET;
			bm_bar_q     <= `ACFG_BAR_RESET;
			board_q      <= {`ACFG_BOARD_RESET, `ACFG_BOARD_RESET};
			board_lock_q <= 1'b0;
			int_line_q   <= `ACFG_INT_LINE_RESET;
		end else begin
			io_en_q      <= io_en_d;
			master_en_q  <= master_en_d;
			abort_flag_q <= abort_flag_d;
			mixer_bar_q  <= mixer_bar_d;
			bm_bar_q     <= bm_bar_d;
			board_q      <= board_d;
			board_lock_q <= board_lock_d;
			int_line_q   <= int_line_d;
		end
	end

	// ------------------------------------------------------------------------
	// Configuration answer
	// ------------------------------------------------------------------------
	// Acknowledge every request one cycle later; reads return the word
	always_comb begin
		rsp_d.ack   = cfg_req_in.valid;
		rsp_d.rdata = 32'h0000_0000;
		if (cfg_req_in.valid && !cfg_req_in.write) begin
			rsp_d.rdata = read_word;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rsp_q <= '0;
		end else begin
			rsp_q <= rsp_d;
		end
	end

	// ------------------------------------------------------------------------
	// Bus-master gate and I/O decode
	// ------------------------------------------------------------------------
	always_comb begin
		// no grant unless master enable is set
		grant_d     = master_req_in & master_en_d;
		claim_mix_d = 1'b0;
		claim_bm_d  = 1'b0;
		// claim I/O only while decode is enabled
		if (io_req_in.valid && io_en_q) begin
			claim_mix_d = ((io_req_in.addr & 16'(`ACFG_WM_MIXER_BAR))
				== (mixer_bar_q[15:0] & 16'(`ACFG_WM_MIXER_BAR)));
			claim_bm_d  = ((io_req_in.addr & 16'(`ACFG_WM_BM_BAR))
				== (bm_bar_q[15:0] & 16'(`ACFG_WM_BM_BAR)));
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			grant_q     <= 1'b0;
			claim_mix_q <= 1'b0;
			claim_bm_q  <= 1'b0;
		end else begin
			grant_q     <= grant_d;
			claim_mix_q <= claim_mix_d;
			claim_bm_q  <= claim_bm_d;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs, all straight from flip-flops except the memory claim, tied low
	// ------------------------------------------------------------------------
	assign cfg_rsp_out        = rsp_q;
	assign master_grant_out   = grant_q;
	assign io_claim_mixer_out = claim_mix_q;
	assign io_claim_bm_out    = claim_bm_q;
	assign mem_claim_out      = 1'b0;
	assign io_enable_out      = io_en_q;
	assign master_enable_out  = master_en_q;

endmodule // audio_function_pci_config_space

`default_nettype wire

/* File: bench/acfg_props.sv */
/*
 * Port checker of the audio function configuration header.
 * Assumes a bind to the top module; one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module acfg_props
	import acfg_pkg::*;
#(
	parameter logic [15:0] MAKER_CODE = 16'h1234 // Arbitrary value
) (
	input wire logic     clk_in,
	input wire logic     rstn_in,
	input wire cfg_req_t cfg_req_in,
	input wire cfg_rsp_t cfg_rsp_out,
	input wire logic     master_req_in,
	input wire logic     master_grant_out,
	input wire io_req_t  io_req_in,
	input wire logic     io_claim_mixer_out,
	input wire logic     io_claim_bm_out,
	input wire logic     mem_claim_out,
	input wire logic     io_enable_out,
	input wire logic     master_enable_out
);
	// Request kind and word index
	wire logic       rd   = cfg_req_in.valid & ~cfg_req_in.write;
	wire logic       wr   = cfg_req_in.valid & cfg_req_in.write;
	wire logic [5:0] word = cfg_req_in.addr[7:2];

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	chk_ack_next: assert property (cfg_req_in.valid |=> cfg_rsp_out.ack)
		else $error("no ack after request");
	chk_ack_cause: assert property (cfg_rsp_out.ack |-> $past(cfg_req_in.valid))
		else $error("ack without request");
	chk_reserved_zero: assert property (rd && word >= 6'h10 |=> !cfg_rsp_out.rdata)
		else $error("reserved word not zero");
	chk_maker_fixed: assert property (rd && word == 6'h00
		|=> cfg_rsp_out.rdata[15:0] == MAKER_CODE) else $error("maker code wrong");
	chk_mem_never: assert property (!mem_claim_out)
		else $error("memory cycle claimed");
	chk_cmd_zeros: assert property (rd && word == 6'h01 |=>
		cfg_rsp_out.rdata[15:3] == 13'h0000 && !cfg_rsp_out.rdata[1]
		&& cfg_rsp_out.rdata[0] == io_enable_out && cfg_rsp_out.rdata[2] == master_enable_out)
		else $error("command bits wrong");
	chk_grant_gate: assert property (1'b1 |=>
		master_grant_out == ($past(master_req_in) && master_enable_out))
		else $error("grant not gated");
	chk_claim_gate: assert property (io_claim_mixer_out || io_claim_bm_out |->
		$past(io_enable_out) && $past(io_req_in.valid)) else $error("claim not gated");
	chk_enable_reset: assert property (!$past(rstn_in) |-> !io_enable_out)
		else $error("decode on after reset");
	chk_enable_write: assert property (wr && word == 6'h01 && cfg_req_in.be[0] |=>
		io_enable_out == $past(cfg_req_in.wdata[0])
		&& master_enable_out == $past(cfg_req_in.wdata[2])) else $error("enables not written");

	// Main scenarios reached
	cov_grant: cover property (master_grant_out);
	cov_mixer: cover property (io_claim_mixer_out);
	cov_bm: cover property (io_claim_bm_out);
endmodule // acfg_props

`default_nettype wire

/* File: bench/cfg_host_model.sv */
/*
 * Host bridge model issuing configuration cycles.
 * Assumes its task is called at a falling edge of clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module cfg_host_model
	import acfg_pkg::*;
(
	input  wire logic     clk_in,
	input  wire cfg_rsp_t cfg_rsp_in,
	output var  cfg_req_t cfg_req_out
);
	initial cfg_req_out = '0;

	// One request cycle; an idle cycle scrambles the released fields
	task automatic issue(input logic v, input logic w, input logic [7:0] a,
		input logic [3:0] b, input logic [31:0] d, output cfg_rsp_t r);
		if (v) begin
			cfg_req_out = '{1'b1, w, a, b, d};
		end else begin
			cfg_req_out = '{1'b0, 1'b0, ~cfg_req_out.addr, ~cfg_req_out.be, ~cfg_req_out.wdata};
		end
		@(negedge clk_in);
		r = cfg_rsp_in;
	endtask
endmodule // cfg_host_model

`default_nettype wire

/* File: bench/audio_function_pci_config_space_test.sv */
/*
 * Self-checking bench of the configuration header with a shadow model.
 * Assumes the host model and the checker files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

`include "acfg_params.svh"

module audio_function_pci_config_space_test;
	import acfg_pkg::*;
	localparam logic [15:0] MAKER = 16'h4d3c; // Arbitrary value
	localparam logic [15:0] PART  = 16'h2b1a; // Arbitrary value
	localparam logic [7:0]  REV   = 8'h07;    // Arbitrary value
	localparam logic [5:0]  PICK [8] = '{6'h00, 6'h01, 6'h01, 6'h04, 6'h05, 6'h0b, 6'h0f, 6'h06};
	logic        clk_in, rstn_in, mreq, mabort, grant, claim_mx, claim_bm, mem_claim, io_en, m_en;
	logic        lock;
	logic [31:0] shw [64];
	logic [31:0] r, d;
	logic [5:0]  wd;
	cfg_req_t    req;
	cfg_rsp_t    rsp, got;
	io_req_t     io;
	int          fails, compares;
	int          seed = 32'h0000_cd0d;

	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	cfg_host_model host (.clk_in(clk_in), .cfg_rsp_in(rsp), .cfg_req_out(req));
	audio_function_pci_config_space #(
		.MAKER_CODE(MAKER), .PART_CODE(PART), .REVISION_CODE(REV)
	) dut (
		.clk_in(clk_in), .rstn_in(rstn_in), .cfg_req_in(req), .cfg_rsp_out(rsp),
		.master_req_in(mreq), .master_abort_in(mabort), .master_grant_out(grant),
		.io_req_in(io), .io_claim_mixer_out(claim_mx), .io_claim_bm_out(claim_bm),
		.mem_claim_out(mem_claim), .io_enable_out(io_en), .master_enable_out(m_en)
	);

	// ------------------------------------------------------------------
	// Compare, model and closing tasks
	// ------------------------------------------------------------------
	task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cmp1(input logic g, input logic e);
		cmp32({31'h0, g}, {31'h0, e});
	endtask
	function automatic logic [31:0] wmask(input logic [5:0] w);
		case (w)
			6'h01: return 32'h0000_0005;
			6'h04: return `ACFG_WM_MIXER_BAR;
			6'h05: return `ACFG_WM_BM_BAR;
			6'h0b: return lock ? 32'h0000_0000 : 32'hffff_ffff;
			6'h0f: return 32'h0000_00ff;
			default: return 32'h0000_0000;
		endcase
	endfunction
	// Reset held four cycles; shadow back to defaults
	task automatic do_reset();
		rstn_in = 1'b0;
		for (int i = 0; i < 64; i++) shw[i] = 32'h0000_0000;
		shw[0] = {PART, MAKER};
		shw[1] = {`ACFG_STA_FIXED, 16'h0000};
		shw[2] = {8'h04, 8'h01, 8'h00, REV};
		shw[4] = 32'h0000_0001;
		shw[5] = 32'h0000_0001;
		shw[6] = 32'h0000_0001;
		shw[15] = 32'h0000_0200;
		lock = 1'b0;
		repeat (4) @(negedge clk_in);
		rstn_in = 1'b1;
	endtask
	// One cycle: expectations from the shadow, then the request
	task automatic step(input logic v, input logic w, input logic [5:0] a,
		input logic [3:0] b, input logic [31:0] x);
		logic [31:0] m, exp;
		logic        e_mx, e_bm;
		m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & wmask(a);
		e_mx = io.valid && shw[1][0] && io.addr[15:8] == shw[4][15:8];
		e_bm = io.valid && shw[1][0] && io.addr[15:6] == shw[5][15:6];
		exp = (v && !w) ? shw[a] : 32'h0000_0000;
		if (v && w) begin
			shw[a] = (shw[a] & ~m) | (x & m);
			if (a == 6'h01 && b[3] && x[29]) shw[1][29] = 1'b0;
			if (a == 6'h0b && |b) lock = 1'b1;
		end
		if (mabort) shw[1][29] = 1'b1;
		host.issue(v, w, {a, 2'b00}, b, x, got);
		cmp1(got.ack, v);
		cmp32(got.rdata, exp);
		cmp1(claim_mx, e_mx);
		cmp1(claim_bm, e_bm);
		cmp1(grant, mreq && shw[1][2]);
		cmp1(mem_claim, 1'b0);
		cmp1(io_en, shw[1][0]);
		cmp1(m_en, shw[1][2]);
	endtask
	task automatic wrap_up();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Watchdog: the run needs about 750 cycles, 3.75 us
	initial begin
		#20000;
		fails++;
		wrap_up();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		mreq = 1'b0;
		mabort = 1'b0;
		io = '0;
		do_reset();
		for (int i = 0; i < 64; i++) step(1'b1, 1'b0, 6'(i), 4'hf, 32'h0000_0000);
		// Ones into fixed fields, then base before decode enable
		step(1'b1, 1'b1, 6'h00, 4'hf, 32'hffff_ffff);
		step(1'b1, 1'b1, 6'h01, 4'h3, 32'h0000_fffe);
		step(1'b1, 1'b0, 6'h01, 4'hf, 32'h0000_0000);
		step(1'b1, 1'b1, 6'h04, 4'hf, 32'hffff_ab00);
		step(1'b1, 1'b1, 6'h01, 4'h1, 32'h0000_0005);
		mreq = 1'b1;
		io = '{1'b1, 16'hab10};
		step(1'b0, 1'b0, 6'h00, 4'h0, 32'h0000_0000);
		io.valid = 1'b0;
		step(1'b1, 1'b1, 6'h01, 4'h1, 32'h0000_0000);
		io.valid = 1'b1;
		step(1'b1, 1'b0, 6'h01, 4'h0, 32'h0000_0000);
		mreq = 1'b0;
		io.valid = 1'b0;
		// Abort flag: setting wins over a clearing write
		mabort = 1'b1;
		step(1'b1, 1'b1, 6'h01, 4'h8, 32'h2000_0000);
		mabort = 1'b0;
		step(1'b1, 1'b0, 6'h01, 4'h0, 32'h0000_0000);
		step(1'b1, 1'b1, 6'h01, 4'h8, 32'h2000_0000);
		step(1'b1, 1'b0, 6'h01, 4'h0, 32'h0000_0000);
		// Random traffic biased to the live words
		for (int i = 0; i < 600; i++) begin
			r = $random(seed);
			d = $random(seed);
			wd = r[4] ? PICK[r[7:5]] : r[13:8];
			mreq = r[15];
			mabort = r[19:16] == 4'h0;
			io.valid = r[3] & ~r[14];
			io.addr = r[1] ? {shw[4][15:8], d[7:0]}
				: (r[2] ? {shw[5][15:6], d[5:0]} : d[31:16]);
			step(r[20] | r[21], r[14], wd, r[25:22], d);
		end
		mreq = 1'b0;
		mabort = 1'b0;
		io.valid = 1'b0;
		do_reset();
		for (int i = 0; i < 64; i++) step(1'b1, 1'b0, 6'(i), 4'hf, 32'h0000_0000);
		wrap_up();
	end
endmodule // audio_function_pci_config_space_test

bind audio_function_pci_config_space acfg_props #(.MAKER_CODE(MAKER_CODE)) props (
	.clk_in(clk_in), .rstn_in(rstn_in), .cfg_req_in(cfg_req_in), .cfg_rsp_out(cfg_rsp_out),
	.master_req_in(master_req_in), .master_grant_out(master_grant_out),
	.io_req_in(io_req_in), .io_claim_mixer_out(io_claim_mixer_out),
	.io_claim_bm_out(io_claim_bm_out), .mem_claim_out(mem_claim_out),
	.io_enable_out(io_enable_out), .master_enable_out(master_enable_out)
);

`default_nettype wire
